// ### hw/asspi_map.svh
// Register offsets, field positions, reset values and timing counts of the angle sensor serial port.
// ****************************************************************
// Behaviour
// - Mode 3: clock and select idle high, sample on rising edge, MSB first.
// - Slave only; 16 bits shift in while 16 bits shift out.
// - Beyond 16 clocks, an 8-bit sample index follows the angle, 24 bits.
// - Register 3 holds the full 8-bit bias-trim magnitude.
// - Zero offset: bits 11..4 in register 4, bits 3..0 in register 5 low nibble.
// - Register 5 bit 4 enables trimming of the X-axis bias current.
// - Register 5 bit 5 enables trimming of the Y-axis bias current.
// - Both enables set reduce both axes equally, no side-shaft correction.
// - Bias-trim magnitude is unsigned, 0 to 255.
// - Register 9 bits 3,4,5 request permanent storage of registers 3,4,5.
// - A new angle sample arrives at 500 kHz, open loop.
// - Write word is command 0010, address, value; effective immediately.
// - Read command 0001 returns angle high byte then register content.
// - Sample index counts 0..255, one per buffer refresh, wraps.
// - Select low freezes the output buffer until select returns high.
// ****************************************************************
`ifndef ASSPI_MAP_SVH
`define ASSPI_MAP_SVH
`define ASSPI_CMD_READ 4'h1
`define ASSPI_CMD_WRITE 4'h2
`define ASSPI_ADDR_TRIM 4'h3
`define ASSPI_ADDR_ZHI 4'h4
`define ASSPI_ADDR_ZLO 4'h5
`define ASSPI_ADDR_FUSE 4'h9
`define ASSPI_XEN_BIT 4
`define ASSPI_YEN_BIT 5
`define ASSPI_ZLO_MASK 8'h3f
`define ASSPI_FUSE_MASK 8'h38
`define ASSPI_RESET_VAL 8'h00
`define ASSPI_WORD_BITS 16
`define ASSPI_FULL_BITS 24
`define ASSPI_CLK_HZ 40000000
`define ASSPI_SAMPLE_HZ 500000
`define ASSPI_SAMPLE_CYC (`ASSPI_CLK_HZ / `ASSPI_SAMPLE_HZ)
`endif

// ### hw/asspi_pkg.sv
// Types of the angle sensor serial port.
package asspi_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_DONE} asspi_state_t;
    typedef logic [7:0] asspi_byte_t;
endpackage

// ### hw/asspi_cfg_if.sv
// Write and read path between the serial engine and the register file.
`timescale 1ns/1ps
`default_nettype none
interface asspi_cfg_if;
    logic wr_en;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport engine (output wr_en, output addr, output wdata, input rdata);
    modport regs (input wr_en, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// ### hw/asspi_regs.sv
// Configuration register file of the angle sensor.
`timescale 1ns/1ps
`default_nettype none
`include "asspi_map.svh"
module asspi_regs
(
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst_n,
    // Register access.
    asspi_cfg_if.regs cfg,
    // Configuration out.
    output logic [7:0] bias_trim_magnitude,
    output logic [11:0] zero_offset,
    output logic x_trim_enable,
    output logic y_trim_enable,
    output logic [2:0] fuse_store_request_bit
);
    logic [7:0] trim_r, trim_nxt, zhi_r, zhi_nxt, zlo_r, zlo_nxt, fuse_r, fuse_nxt;

    // Writes land at once; unmapped addresses fall through untouched.
    always_comb
    begin
        trim_nxt = trim_r;
        zhi_nxt = zhi_r;
        zlo_nxt = zlo_r;
        fuse_nxt = fuse_r;
        if (cfg.wr_en)
        begin
            case (cfg.addr)
                `ASSPI_ADDR_TRIM: trim_nxt = cfg.wdata;
                `ASSPI_ADDR_ZHI: zhi_nxt = cfg.wdata;
                `ASSPI_ADDR_ZLO: zlo_nxt = cfg.wdata & `ASSPI_ZLO_MASK;
                `ASSPI_ADDR_FUSE: fuse_nxt = cfg.wdata & `ASSPI_FUSE_MASK;
                default: trim_nxt = trim_r;
            endcase
        end
    end

    // Registers reset to the unprogrammed value.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            trim_r <= `ASSPI_RESET_VAL;
            zhi_r <= `ASSPI_RESET_VAL;
            zlo_r <= `ASSPI_RESET_VAL;
            fuse_r <= `ASSPI_RESET_VAL;
        end
        else
        begin
            trim_r <= trim_nxt;
            zhi_r <= zhi_nxt;
            zlo_r <= zlo_nxt;
            fuse_r <= fuse_nxt;
        end
    end

    // Read mux; unmapped addresses read zero.
    always_comb
    begin
        case (cfg.addr)
            `ASSPI_ADDR_TRIM: cfg.rdata = trim_r;
            `ASSPI_ADDR_ZHI: cfg.rdata = zhi_r;
            `ASSPI_ADDR_ZLO: cfg.rdata = zlo_r;
            `ASSPI_ADDR_FUSE: cfg.rdata = fuse_r;
            default: cfg.rdata = 8'h00;
        endcase
    end

    // Both enables set trim both axes by the same magnitude.
    assign bias_trim_magnitude = trim_r;
    assign zero_offset = {zhi_r, zlo_r[3:0]};
    assign x_trim_enable = zlo_r[`ASSPI_XEN_BIT];
    assign y_trim_enable = zlo_r[`ASSPI_YEN_BIT];
    assign fuse_store_request_bit = fuse_r[5:3];

    property p_zlo_zero;
        @(posedge clk_sys) disable iff (!rst_n)
        zlo_r[7:6] == 2'b00;
    endproperty
    a_zlo_zero: assert property (p_zlo_zero) else $error("zero-low upper bits not zero");
    property p_fuse_zero;
        @(posedge clk_sys) disable iff (!rst_n)
        (fuse_r & ~`ASSPI_FUSE_MASK) == 8'h00;
    endproperty
    a_fuse_zero: assert property (p_fuse_zero) else $error("fuse spare bits set");
    property p_trim_wr;
        @(posedge clk_sys) disable iff (!rst_n)
        cfg.wr_en && cfg.addr == `ASSPI_ADDR_TRIM |=> trim_r == $past(cfg.wdata);
    endproperty
    a_trim_wr: assert property (p_trim_wr) else $error("trim write lost");
    property p_unmapped;
        @(posedge clk_sys) disable iff (!rst_n)
        cfg.wr_en && cfg.addr != `ASSPI_ADDR_TRIM && cfg.addr != `ASSPI_ADDR_ZHI && cfg.addr != `ASSPI_ADDR_ZLO
            && cfg.addr != `ASSPI_ADDR_FUSE |=> $stable(trim_r) && $stable(zhi_r) && $stable(zlo_r) && $stable(fuse_r);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped write changed state");
endmodule
`default_nettype wire

// ### hw/asspi_sampler.sv
// Sample pacer: refreshes the output buffer at the front-end rate unless frozen.
`timescale 1ns/1ps
`default_nettype none
`include "asspi_map.svh"
module asspi_sampler
(
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst_n,
    // Front end and freeze.
    input wire logic [15:0] fe_angle,
    input wire logic freeze,
    // Output buffer.
    output logic [15:0] buf_angle,
    output logic [7:0] buf_index
);
    localparam int CYC = `ASSPI_SAMPLE_CYC;
    logic [6:0] cnt_r, cnt_nxt;
    logic [15:0] ang_r, ang_nxt;
    logic [7:0] idx_r, idx_nxt;
    logic tick;

    // A sample that comes due while frozen is dropped, and the index does not count it.
    always_comb
    begin
        tick = (cnt_r == 7'(CYC - 1));
        cnt_nxt = tick ? 7'd0 : cnt_r + 7'd1;
        ang_nxt = ang_r;
        idx_nxt = idx_r;
        if (tick && !freeze)
        begin
            ang_nxt = fe_angle;
            idx_nxt = idx_r + 8'd1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_r <= 7'd0;
            ang_r <= 16'h0000;
            idx_r <= 8'h00;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            ang_r <= ang_nxt;
            idx_r <= idx_nxt;
        end
    end

    assign buf_angle = ang_r;
    assign buf_index = idx_r;

    property p_freeze;
        @(posedge clk_sys) disable iff (!rst_n)
        freeze |=> $stable(buf_angle) && $stable(buf_index);
    endproperty
    a_freeze: assert property (p_freeze) else $error("buffer changed while frozen");
    property p_idx;
        @(posedge clk_sys) disable iff (!rst_n)
        $changed(buf_index) |-> buf_index == 8'($past(buf_index) + 8'd1);
    endproperty
    a_idx: assert property (p_idx) else $error("index step wrong");
    property p_rate;
        @(posedge clk_sys) disable iff (!rst_n)
        tick |=> !tick [*8];
    endproperty
    a_rate: assert property (p_rate) else $error("sample ticks too close");
endmodule
`default_nettype wire

// ### hw/asspi_top.sv
// Serial slave port of the angle sensor: mode 3 shift engine, command decode, buffer and registers.
`timescale 1ns/1ps
`default_nettype none
`include "asspi_map.svh"
module asspi_top
(
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst_n,
    // Serial pins.
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe,
    // Front end.
    input wire logic [15:0] fe_angle,
    // Configuration toward the analog trim and fuse logic.
    output logic [7:0] bias_trim_magnitude,
    output logic [11:0] zero_offset,
    output logic x_trim_enable,
    output logic y_trim_enable,
    output logic [2:0] fuse_store_request_bit
);
    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [1:0] sclk_s_r, cs_s_r, mosi_s_r;
    logic sclk_d_r, cs_d_r;

    // Two stages before any logic looks at a pin; a third bit keeps edge history.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sclk_s_r <= 2'b11;
            cs_s_r <= 2'b11;
            mosi_s_r <= 2'b00;
            sclk_d_r <= 1'b1;
            cs_d_r <= 1'b1;
        end
        else
        begin
            sclk_s_r <= {sclk_s_r[0], spi_sclk};
            cs_s_r <= {cs_s_r[0], spi_cs_n};
            mosi_s_r <= {mosi_s_r[0], spi_mosi};
            sclk_d_r <= sclk_s_r[1];
            cs_d_r <= cs_s_r[1];
        end
    end

    logic sclk_q, cs_q, mosi_q, sclk_rise, sclk_fall, cs_fall;
    assign sclk_q = sclk_s_r[1];
    assign cs_q = cs_s_r[1];
    assign mosi_q = mosi_s_r[1];
    assign sclk_rise = !cs_q && sclk_q && !sclk_d_r;
    assign sclk_fall = !cs_q && !sclk_q && sclk_d_r;
    assign cs_fall = !cs_q && cs_d_r;

    // ****************************************************************
    // Sampler and register file
    // ****************************************************************
    logic [15:0] buf_angle;
    logic [7:0] buf_index;
    asspi_cfg_if cfg ();

    asspi_sampler u_sampler
    (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .fe_angle(fe_angle),
        .freeze(!cs_q),
        .buf_angle(buf_angle),
        .buf_index(buf_index)
    );

    asspi_regs u_regs
    (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .cfg(cfg.regs),
        .bias_trim_magnitude(bias_trim_magnitude),
        .zero_offset(zero_offset),
        .x_trim_enable(x_trim_enable),
        .y_trim_enable(y_trim_enable),
        .fuse_store_request_bit(fuse_store_request_bit)
    );

    // ****************************************************************
    // Shift engine
    // ****************************************************************
    asspi_pkg::asspi_state_t st_r, st_nxt;
    logic [4:0] cnt_r, cnt_nxt;
    logic [15:0] rx_r, rx_nxt;
    logic [23:0] tx_r, tx_nxt;
    logic miso_r, miso_nxt;
    logic wr_nxt, wr_r;
    logic [3:0] addr_r, addr_nxt;
    logic [7:0] wdata_r, wdata_nxt;
    logic [15:0] rx_shift;
    logic rd_load_r, rd_load_nxt;

    // Decode of a finished command byte, used for the read swap and the write.
    function automatic logic is_cmd(input logic [3:0] c, input logic [3:0] want);
        is_cmd = (c == want);
    endfunction

    // The buffer is already frozen at the select edge, so the loaded word is coherent.
    always_comb
    begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        rx_nxt = rx_r;
        tx_nxt = tx_r;
        miso_nxt = miso_r;
        wr_nxt = 1'b0;
        addr_nxt = addr_r;
        wdata_nxt = wdata_r;
        rd_load_nxt = 1'b0;
        rx_shift = {rx_r[14:0], mosi_q};
        case (st_r)
            asspi_pkg::ST_IDLE:
            begin
                if (cs_fall)
                begin
                    st_nxt = asspi_pkg::ST_SHIFT;
                    cnt_nxt = 5'd0;
                    tx_nxt = {buf_angle, buf_index};
                end
            end
            asspi_pkg::ST_SHIFT:
            begin
                if (cs_q)
                    st_nxt = asspi_pkg::ST_IDLE;
                else
                begin
                    // The register byte replaces the angle low byte one cycle after the address lands.
                    if (rd_load_r)
                        tx_nxt = {cfg.rdata, tx_r[15:0]};
                    if (sclk_fall)
                    begin
                        miso_nxt = tx_r[23];
                        tx_nxt = {tx_r[22:0], 1'b0};
                    end
                    if (sclk_rise)
                    begin
                        rx_nxt = rx_shift;
                        cnt_nxt = cnt_r + 5'd1;
                        if (cnt_r == 5'd7 && is_cmd(rx_shift[7:4], `ASSPI_CMD_READ))
                        begin
                            addr_nxt = rx_shift[3:0];
                            rd_load_nxt = 1'b1;
                        end
                        if (cnt_r == 5'd15)
                        begin
                            st_nxt = asspi_pkg::ST_DONE;
                            if (is_cmd(rx_shift[15:12], `ASSPI_CMD_WRITE))
                            begin
                                wr_nxt = 1'b1;
                                addr_nxt = rx_shift[11:8];
                                wdata_nxt = rx_shift[7:0];
                            end
                        end
                    end
                end
            end
            asspi_pkg::ST_DONE:
            begin
                if (cs_q)
                    st_nxt = asspi_pkg::ST_IDLE;
                else if (sclk_fall)
                begin
                    miso_nxt = tx_r[23];
                    tx_nxt = {tx_r[22:0], 1'b0};
                end
            end
            default: st_nxt = asspi_pkg::ST_IDLE;
        endcase
    end

    // Shift engine state; only registers the values computed above.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r <= asspi_pkg::ST_IDLE;
            cnt_r <= 5'd0;
            rx_r <= 16'h0000;
            tx_r <= 24'h000000;
            miso_r <= 1'b0;
            wr_r <= 1'b0;
            addr_r <= 4'h0;
            wdata_r <= 8'h00;
            rd_load_r <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            rx_r <= rx_nxt;
            tx_r <= tx_nxt;
            miso_r <= miso_nxt;
            wr_r <= wr_nxt;
            addr_r <= addr_nxt;
            wdata_r <= wdata_nxt;
            rd_load_r <= rd_load_nxt;
        end
    end

    // Register access and data pin; the pin is driven only while a frame is open.
    assign cfg.wr_en = wr_r;
    assign cfg.addr = addr_r;
    assign cfg.wdata = wdata_r;
    assign spi_miso = miso_r;
    assign spi_miso_oe = (st_r != asspi_pkg::ST_IDLE);

    property p_wr_pulse;
        @(posedge clk_sys) disable iff (!rst_n)
        wr_r |=> !wr_r;
    endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe longer than one cycle");
    property p_load;
        @(posedge clk_sys) disable iff (!rst_n)
        st_r == asspi_pkg::ST_IDLE && cs_fall |=> tx_r == {$past(buf_angle), $past(buf_index)};
    endproperty
    a_load: assert property (p_load) else $error("frame not loaded from buffer");
endmodule
`default_nettype wire

// ### testbench/asspi_master.sv
// Behavioural serial master that drives the angle sensor port in clock-idle-high mode.
`timescale 1ns/1ps
`default_nettype none
module asspi_master
(
    // Serial pins toward the port.
    output logic spi_sclk,
    output logic spi_cs_n,
    output logic spi_mosi,
    // Data line as seen by the master.
    input wire logic spi_miso_line,
    input wire logic spi_miso_oe
);
    localparam time HALF = 100;
    logic oe_fault;

    // Clock and select start idle high; the link clock stands still between frames.
    initial
    begin
        spi_sclk = 1'b1;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b1;
        oe_fault = 1'b0;
    end

    // One frame: data changes on falling edges and is sampled on rising edges, most significant bit first.
    // Bits beyond sixteen are sent as zero, so a 24-clock frame carries a 16-bit word plus padding.
    task automatic xfer(input logic [15:0] tx, input int nbits, input time hold, output logic [23:0] rx);
        logic [23:0] sh;
        sh = {tx, 8'h00};
        rx = 24'h000000;
        spi_cs_n = 1'b0;
        #(HALF + hold);
        for (int i = 0; i < nbits; i++)
        begin
            spi_sclk = 1'b0;
            spi_mosi = sh[23 - i];
            #HALF;
            spi_sclk = 1'b1;
            rx = {rx[22:0], spi_miso_line};
            if (spi_miso_oe !== 1'b1)
                oe_fault = 1'b1;
            #HALF;
        end
        #HALF;
        spi_cs_n = 1'b1;
        // A released data line shows the inverse of its last bit, never a stale copy.
        spi_mosi = ~spi_mosi;
        #(4 * HALF);
    endtask
endmodule
`default_nettype wire

// ### testbench/asspi_top_tb.sv
// Self-checking testbench of the angle sensor serial port.
`timescale 1ns/1ps
`default_nettype none
`include "asspi_map.svh"
module asspi_top_tb;
    // ****************************************************************
    // Clock, reset and wiring
    // ****************************************************************
    logic clk_sys;
    logic rst_n;
    logic spi_sclk;
    logic spi_cs_n;
    logic spi_mosi;
    logic spi_miso;
    logic spi_miso_oe;
    logic miso_last;
    logic miso_line;
    logic [15:0] fe_angle;
    logic [7:0] bias_trim_magnitude;
    logic [11:0] zero_offset;
    logic x_trim_enable;
    logic y_trim_enable;
    logic [2:0] fuse_store_request_bit;
    int fail_count;
    int tests_run;

    // A released data line has no pull, so the master sees the inverse of the last driven bit.
    always @*
    begin
        if (spi_miso_oe === 1'b1)
            miso_last = spi_miso;
    end
    assign miso_line = (spi_miso_oe === 1'b1) ? spi_miso : ~miso_last;

    asspi_top u_asspi_top (.clk_sys(clk_sys), .rst_n(rst_n), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
        .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .fe_angle(fe_angle),
        .bias_trim_magnitude(bias_trim_magnitude), .zero_offset(zero_offset), .x_trim_enable(x_trim_enable),
        .y_trim_enable(y_trim_enable), .fuse_store_request_bit(fuse_store_request_bit));
    asspi_master u_asspi_master (.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
        .spi_miso_line(miso_line), .spi_miso_oe(spi_miso_oe));

    // The system clock runs at 40 MHz.
    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    // Compares one value and counts it.
    task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
        tests_run++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        logic [23:0] rx;
        u_asspi_master.xfer({`ASSPI_CMD_WRITE, a, v}, 16, 0, rx);
    endtask

    task automatic rd(input logic [3:0] a, output logic [15:0] r);
        logic [23:0] rx;
        u_asspi_master.xfer({`ASSPI_CMD_READ, a, 8'h00}, 16, 0, rx);
        r = rx[15:0];
    endtask

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset;
        chk({bias_trim_magnitude, zero_offset, x_trim_enable, y_trim_enable, 2'b00}, 24'h0, "reset cfg");
        chk({21'h0, fuse_store_request_bit}, 24'h0, "reset fuse");
    endtask

    // Plain 16-bit readout, then a 24-bit readout; the data line must be driven throughout.
    task automatic t_angle;
        logic [23:0] rx;
        @(negedge clk_sys);
        fe_angle = 16'hc35a;
        repeat (200) @(negedge clk_sys);
        u_asspi_master.xfer(16'h0000, 16, 0, rx);
        chk(rx, 24'h00c35a, "angle16");
        u_asspi_master.xfer(16'h0000, 24, 0, rx);
        chk({8'h0, rx[23:8]}, 24'h00c35a, "angle24");
        chk({23'h0, u_asspi_master.oe_fault}, 24'h0, "miso driven");
        chk({23'h0, spi_miso_oe}, 24'h0, "miso released");
    endtask

    // Loads 41.1 us apart, 5 us of it frozen: 1444 live cycles hold 18 or 19 refreshes.
    task automatic t_index;
        logic [23:0] r0;
        logic [23:0] r1;
        logic [7:0] d;
        u_asspi_master.xfer(16'h0000, 24, 0, r0);
        #35700;
        u_asspi_master.xfer(16'h0000, 24, 0, r1);
        d = r1[7:0] - r0[7:0];
        chk({23'h0, d == 8'd18 || d == 8'd19}, 24'h1, "index step");
    endtask

    // The angle changes while select is low; the frame must still carry the old sample.
    task automatic t_freeze;
        logic [23:0] rx;
        fork
            u_asspi_master.xfer(16'h0000, 16, 6000, rx);
            begin
                #1000;
                @(negedge clk_sys);
                fe_angle = 16'h1234;
            end
        join
        chk(rx, 24'h00c35a, "frozen");
        repeat (200) @(negedge clk_sys);
        u_asspi_master.xfer(16'h0000, 16, 0, rx);
        chk(rx, 24'h001234, "refreshed");
    endtask

    // Register write, read back, field outputs and unmapped places.
    task automatic t_regs;
        logic [15:0] r;
        logic [7:0] trims [3] = '{8'h00, 8'ha5, 8'hff};
        foreach (trims[i])
        begin
            wr(`ASSPI_ADDR_TRIM, trims[i]);
            chk({16'h0, bias_trim_magnitude}, {16'h0, trims[i]}, "trim out");
            rd(`ASSPI_ADDR_TRIM, r);
            chk({8'h0, r}, {16'h12, trims[i]}, "trim read");
        end
        wr(`ASSPI_ADDR_ZHI, 8'h5c);
        wr(`ASSPI_ADDR_ZLO, 8'hd9);
        chk({12'h0, zero_offset}, 24'h0005c9, "zero");
        rd(`ASSPI_ADDR_ZLO, r);
        chk({16'h0, r[7:0]}, 24'h000019, "zlo read");
        rd(`ASSPI_ADDR_ZHI, r);
        chk({16'h0, r[7:0]}, 24'h00005c, "zhi read");
        for (int e = 0; e < 4; e++)
        begin
            wr(`ASSPI_ADDR_ZLO, {2'b00, e[1:0], 4'h9});
            chk({22'h0, y_trim_enable, x_trim_enable}, {22'h0, e[1:0]}, "enables");
        end
        wr(`ASSPI_ADDR_FUSE, 8'hff);
        chk({21'h0, fuse_store_request_bit}, 24'h7, "fuse out");
        rd(`ASSPI_ADDR_FUSE, r);
        chk({16'h0, r[7:0]}, 24'h000038, "fuse read");
        wr(4'h7, 8'h00);
        wr(4'h2, 8'h00);
        chk({4'h0, bias_trim_magnitude, zero_offset}, 24'h0ff5c9, "unmapped write");
        rd(4'h7, r);
        chk({16'h0, r[7:0]}, 24'h0, "unmapped read");
        rd(4'hf, r);
        chk({16'h0, r[7:0]}, 24'h0, "unmapped read f");
    endtask

    // Watchdog: the whole sequence needs well under 300 us.
    initial
    begin
        #300000;
        fail_count++;
        $display("[ERR] %0t watchdog expired", $time);
        give_verdict();
    end

    // Main sequence.
    initial
    begin
        fail_count = 0;
        tests_run = 0;
        rst_n = 1'b0;
        fe_angle = 16'h0000;
        repeat (4) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (2) @(negedge clk_sys);
        t_reset();
        t_angle();
        t_index();
        t_freeze();
        t_regs();
        give_verdict();
    end
endmodule
`default_nettype wire
